/* File: include/hbsg_pkg.sv */
// shared types and constants for the half-bridge static gate sequencer
package hbsg_pkg;

   // ---------------------------------------------------------------
   // drive selection codes
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_OFF_PASSIVE = 2'h0;
   localparam logic [1:0] SEL_LOW_ON = 2'h1;
   localparam logic [1:0] SEL_HIGH_ON = 2'h2;
   localparam logic [1:0] SEL_OFF_ACTIVE = 2'h3;

   // ---------------------------------------------------------------
   // gate current step numbers and hold levels
   // ---------------------------------------------------------------
   localparam logic [5:0] HOLD_STEP_LOW = 6'h13;  // step 19
   localparam logic [5:0] HOLD_STEP_HIGH = 6'h19; // step 25
   localparam logic [5:0] STEP_ZERO = 6'h00;
   localparam logic [5:0] STEP_MAX = 6'h3f;       // hard-off sink, strongest sink
   localparam int CODE_TO_STEP_SHIFT = 2;         // code n selects step 4n

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int CMD_LATENCY_US = 3;
   localparam int CMD_LATENCY_CYC = CMD_LATENCY_US * CLK_MHZ; // longest, 300 cycles at 100 MHz
   localparam int TIME_W = 16;

   // ---------------------------------------------------------------
   // gate drive action for one fet
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      DRV_PASSIVE = 3'h0, // passive discharge, driver idle
      DRV_CHARGE = 3'h1,  // source current into gate
      DRV_SINK = 3'h2,    // sink current from gate
      DRV_HARDOFF = 3'h3  // clamp with hard-off sink current
   } hbsg_drv_type;

   typedef struct packed
   {
      hbsg_drv_type action;
      logic [5:0] step; // current step number
   } hbsg_gate_type;

   typedef struct packed
   {
      hbsg_gate_type highSide;
      hbsg_gate_type lowSide;
      logic pwmMode;
   } hbsg_bridge_out_type;

   typedef struct packed
   {
      logic [TIME_W-1:0] guardCyc;
      logic [TIME_W-1:0] blankCyc;
      logic [TIME_W-1:0] filterCyc;
   } hbsg_timing_type;

endpackage

/* File: logic/hbsg_sequencer.sv */
// static gate sequencer for two half-bridges
`timescale 1ns/10ps
`default_nettype none

module hbsg_sequencer #(
   parameter int NUM_BRIDGES = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // command strobe pin
   input wire logic chipSelectPin,
   // configuration
   input wire logic charge_pump_enable,
   input wire logic hold_current_select,
   input wire logic [1:0] bridge_drive_select [NUM_BRIDGES],
   input wire logic [NUM_BRIDGES-1:0] bridge_pwm_select,
   input wire logic [3:0] static_gate_current_code [NUM_BRIDGES],
   input wire hbsg_pkg::hbsg_timing_type timing [NUM_BRIDGES],
   // pwm pins
   input wire logic [NUM_BRIDGES-1:0] pwmPin,
   // gate drive outputs
   output var hbsg_pkg::hbsg_bridge_out_type bridgeOut [NUM_BRIDGES],
   output logic [NUM_BRIDGES-1:0] sequenceBusy
);

   // ---------------------------------------------------------------
   // chip-select synchroniser and edge detect
   // ---------------------------------------------------------------
   logic csMeta_q, csSync_q, csLast_q;
   logic [NUM_BRIDGES-1:0] pwmMeta_q, pwmSync_q;
   logic csMeta_d, csSync_d, csLast_d, csRise;
   logic [NUM_BRIDGES-1:0] pwmMeta_d, pwmSync_d;

   // second stage feeds the edge detector, first stage read by nothing else
   always_comb
   begin
      csMeta_d = chipSelectPin;
      csSync_d = csMeta_q;
      csLast_d = csSync_q;
      pwmMeta_d = pwmPin;
      pwmSync_d = pwmMeta_q;
   end

   assign csRise = csSync_q & ~csLast_q; // 3 cycles latency, well inside 3 us

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         csMeta_q <= 1'b1;
         csSync_q <= 1'b1;
         csLast_q <= 1'b1;
         pwmMeta_q <= '0;
         pwmSync_q <= '0;
      end
      else if (clkEn)
      begin
         csMeta_q <= csMeta_d;
         csSync_q <= csSync_d;
         csLast_q <= csLast_d;
         pwmMeta_q <= pwmMeta_d;
         pwmSync_q <= pwmSync_d;
      end
   end

   // ---------------------------------------------------------------
   // per-bridge sequencer
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,  // settled, drive follows latched selection
      ST_GUARD = 5'h02, // cross-conduction guard
      ST_BLANK = 5'h04, // blanking
      ST_FILT = 5'h08,  // drain-source filter
      ST_OFFG = 5'h10   // turn-off discharge
   } hbsg_state_type;

   for (genvar b = 0; b < NUM_BRIDGES; b++)
   begin : g_bridge
      localparam int TIME_W_L = hbsg_pkg::TIME_W;
      hbsg_state_type state_q, state_d;
      logic [1:0] sel_q, sel_d;       // command taken at chip-select rise
      logic [TIME_W_L-1:0] cnt_q, cnt_d;
      hbsg_pkg::hbsg_bridge_out_type out_q, out_d;
      logic busy_q, busy_d;
      logic [5:0] statStep, holdStep;
      logic highTarget;
      logic cmdOn;

      // code n maps to step 4n; hold picks 19 or 25
      assign statStep = {static_gate_current_code[b], 2'b00};
      assign holdStep = hold_current_select ? hbsg_pkg::HOLD_STEP_HIGH
                                            : hbsg_pkg::HOLD_STEP_LOW;
      // next selection, so the first blank cycle already drives the new target
      assign highTarget = (sel_d == hbsg_pkg::SEL_HIGH_ON);
      assign cmdOn = (bridge_drive_select[b] == hbsg_pkg::SEL_LOW_ON) ||
                     (bridge_drive_select[b] == hbsg_pkg::SEL_HIGH_ON);

      // next state: commands taken only on the synchronised chip-select rise
      always_comb
      begin
         state_d = state_q;
         sel_d = sel_q;
         cnt_d = cnt_q;
         if (cnt_q != '0)
            cnt_d = cnt_q - 1'b1;
         if (csRise && (bridge_drive_select[b] != sel_q))
         begin
            sel_d = bridge_drive_select[b];
            if (cmdOn && (sel_q == hbsg_pkg::SEL_OFF_ACTIVE || sel_q == hbsg_pkg::SEL_OFF_PASSIVE))
            begin
               state_d = ST_BLANK; // no guard from off
               cnt_d = timing[b].blankCyc;
            end
            else if (cmdOn)
            begin
               state_d = ST_GUARD; // opposite fet was on
               cnt_d = timing[b].guardCyc;
            end
            else
            begin
               state_d = ST_OFFG;
               cnt_d = timing[b].guardCyc;
            end
         end
         else
         begin
            case (state_q)
               ST_IDLE: state_d = ST_IDLE;
               ST_GUARD:
                  if (cnt_q == '0)
                  begin
                     state_d = ST_BLANK;
                     cnt_d = timing[b].blankCyc;
                  end
               ST_BLANK:
                  if (cnt_q == '0)
                  begin
                     state_d = ST_FILT;
                     cnt_d = timing[b].filterCyc;
                  end
               ST_FILT, ST_OFFG:
                  if (cnt_q == '0)
                     state_d = ST_IDLE;
               default: state_d = ST_IDLE;
            endcase
         end
      end

      // gate drive for the current phase
      always_comb
      begin
         out_d = '0;
         out_d.pwmMode = 1'b0;
         busy_d = (state_d != ST_IDLE);
         if (!charge_pump_enable)
         begin
            out_d.highSide.action = hbsg_pkg::DRV_PASSIVE;
            out_d.lowSide.action = hbsg_pkg::DRV_PASSIVE;
            busy_d = 1'b0;
         end
         else if (bridge_pwm_select[b])
         begin
            // pwm pin drives the selected fet; detailed pwm timing not modelled
            out_d.pwmMode = 1'b1;
            out_d.highSide.action = (sel_q == hbsg_pkg::SEL_HIGH_ON && pwmSync_q[b])
                                    ? hbsg_pkg::DRV_CHARGE : hbsg_pkg::DRV_SINK;
            out_d.lowSide.action = (sel_q == hbsg_pkg::SEL_LOW_ON && pwmSync_q[b])
                                   ? hbsg_pkg::DRV_CHARGE : hbsg_pkg::DRV_SINK;
            out_d.highSide.step = statStep;
            out_d.lowSide.step = statStep;
            busy_d = 1'b0;
         end
         else
         begin
            case (state_d)
               ST_GUARD, ST_OFFG:
               begin
                  out_d.highSide = '{hbsg_pkg::DRV_SINK, statStep};
                  out_d.lowSide = '{hbsg_pkg::DRV_SINK, statStep};
               end
               ST_BLANK, ST_FILT:
               begin
                  // on fet charges, opposite fet clamped hard off
                  out_d.highSide = highTarget ? '{hbsg_pkg::DRV_CHARGE, statStep}
                                             : '{hbsg_pkg::DRV_HARDOFF, hbsg_pkg::STEP_MAX};
                  out_d.lowSide = highTarget ? '{hbsg_pkg::DRV_HARDOFF, hbsg_pkg::STEP_MAX}
                                            : '{hbsg_pkg::DRV_CHARGE, statStep};
               end
               default:
               begin
                  case (sel_d)
                     hbsg_pkg::SEL_LOW_ON:
                     begin
                        out_d.highSide = '{hbsg_pkg::DRV_SINK, holdStep};
                        out_d.lowSide = '{hbsg_pkg::DRV_CHARGE, holdStep};
                     end
                     hbsg_pkg::SEL_HIGH_ON:
                     begin
                        out_d.highSide = '{hbsg_pkg::DRV_CHARGE, holdStep};
                        out_d.lowSide = '{hbsg_pkg::DRV_SINK, holdStep};
                     end
                     hbsg_pkg::SEL_OFF_ACTIVE:
                     begin
                        out_d.highSide = '{hbsg_pkg::DRV_SINK, holdStep};
                        out_d.lowSide = '{hbsg_pkg::DRV_SINK, holdStep};
                     end
                     default:
                     begin
                        out_d.highSide = '{hbsg_pkg::DRV_PASSIVE, hbsg_pkg::STEP_ZERO};
                        out_d.lowSide = '{hbsg_pkg::DRV_PASSIVE, hbsg_pkg::STEP_ZERO};
                     end
                  endcase
               end
            endcase
         end
      end

      always_ff @(posedge core_clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            state_q <= ST_IDLE;
            sel_q <= hbsg_pkg::SEL_OFF_PASSIVE;
            cnt_q <= '0;
            out_q <= '0;
            busy_q <= 1'b0;
         end
         else if (clkEn)
         begin
            state_q <= state_d;
            sel_q <= sel_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            busy_q <= busy_d;
         end
      end

      assign bridgeOut[b] = out_q;
      assign sequenceBusy[b] = busy_q;
   end

endmodule // hbsg_sequencer

`default_nettype wire

/* File: testbench/hbsg_props.sv */
// assertion checker for the gate sequencer, bridge 0
`timescale 1ns/10ps
`default_nettype none

module hbsg_props #(
   parameter int NUM_BRIDGES = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // command and configuration
   input wire logic chipSelectPin,
   input wire logic charge_pump_enable,
   input wire logic hold_current_select,
   input wire logic [1:0] bridge_drive_select [NUM_BRIDGES],
   input wire logic [NUM_BRIDGES-1:0] bridge_pwm_select,
   input wire logic [3:0] static_gate_current_code [NUM_BRIDGES],
   // gate drive
   input wire hbsg_pkg::hbsg_bridge_out_type bridgeOut [NUM_BRIDGES],
   input wire logic [NUM_BRIDGES-1:0] sequenceBusy
);
   localparam int LAT = 300; // command latency bound in clocks
   // ---------------------------------------------------------------
   // helper views
   // ---------------------------------------------------------------
   wire hbsg_pkg::hbsg_gate_type hs = bridgeOut[0].highSide;
   wire hbsg_pkg::hbsg_gate_type ls = bridgeOut[0].lowSide;
   wire logic [5:0] stStep = {static_gate_current_code[0], 2'h0};
   wire logic [5:0] hoStep = hold_current_select ? hbsg_pkg::HOLD_STEP_HIGH : hbsg_pkg::HOLD_STEP_LOW;
   wire logic hsChg = hs.action == hbsg_pkg::DRV_CHARGE;
   wire logic lsSnk = ls.action == hbsg_pkg::DRV_SINK;
   wire logic idle = !sequenceBusy[0] && !bridgeOut[0].pwmMode;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_pump_off_passive: assert property (!charge_pump_enable |=> hs.action == hbsg_pkg::DRV_PASSIVE && ls.action == hbsg_pkg::DRV_PASSIVE)
      else $error("pump off but gate driven");
   a_hardoff_clamp: assert property (ls.action == hbsg_pkg::DRV_HARDOFF |-> ls.step == hbsg_pkg::STEP_MAX && hsChg)
      else $error("hard-off clamp wrong");
   a_static_step: assert property (sequenceBusy[0] && hsChg |-> hs.step == $past(stStep))
      else $error("static charge step wrong");
   a_hold_on: assert property (idle && hsChg |-> hs.step == $past(hoStep))
      else $error("on hold step wrong");
   a_hold_off: assert property (idle && lsSnk |-> ls.step == $past(hoStep))
      else $error("off hold step wrong");
   a_no_cross: assert property (!(hsChg && ls.action == hbsg_pkg::DRV_CHARGE))
      else $error("both gates charged");
   a_guard_sink: assert property ($rose(sequenceBusy[0]) && lsSnk |-> hs.action == hbsg_pkg::DRV_SINK && hs.step == $past(stStep))
      else $error("guard phase drive wrong");
   a_cmd_latency: assert property ($rose(chipSelectPin) && charge_pump_enable && !bridge_pwm_select[0] && bridge_drive_select[0] == hbsg_pkg::SEL_HIGH_ON |-> ##[1:LAT] hsChg)
      else $error("command not carried out");
   a_pwm_flag: assert property (!bridge_pwm_select[0] |=> !bridgeOut[0].pwmMode)
      else $error("pwm mode without select");

   c_guard: cover property ($rose(sequenceBusy[0]) && lsSnk);
   c_hardoff: cover property (ls.action == hbsg_pkg::DRV_HARDOFF);
   c_pwm: cover property (bridgeOut[0].pwmMode);
endmodule // hbsg_props

bind hbsg_sequencer hbsg_props #(.NUM_BRIDGES(NUM_BRIDGES)) u_props (.core_clk, .rst_b,
   .chipSelectPin, .charge_pump_enable, .hold_current_select, .bridge_drive_select,
   .bridge_pwm_select, .static_gate_current_code, .bridgeOut, .sequenceBusy);
`default_nettype wire

/* File: testbench/hbsg_fet_model.sv */
// gate charge model of one external half-bridge
`timescale 1ns/10ps
`default_nettype none

module hbsg_fet_model (
   // clock
   input wire logic core_clk,
   // drive from the sequencer
   input wire hbsg_pkg::hbsg_bridge_out_type drive,
   // both gates above threshold at once
   output logic shootThrough
);
   int hsV = 0;
   int lsV = 0;
   // gates discharge slowly, so a short guard would show as overlap
   function automatic int nv(int v, hbsg_pkg::hbsg_drv_type a);
      int d;
      d = (a == hbsg_pkg::DRV_CHARGE) ? 2 : (a == hbsg_pkg::DRV_HARDOFF) ? -8 : (a == hbsg_pkg::DRV_SINK) ? -2 : -1;
      return (v + d > 8) ? 8 : (v + d < 0) ? 0 : v + d;
   endfunction
   initial shootThrough = 1'b0;
   // latch any overlap of the two gate voltages
   always @(posedge core_clk)
   begin
      hsV <= nv(hsV, drive.highSide.action);
      lsV <= nv(lsV, drive.lowSide.action);
      if (hsV >= 4 && lsV >= 4) shootThrough <= 1'b1;
   end
endmodule // hbsg_fet_model
`default_nettype wire

/* File: testbench/hbsg_sequencer_tb.sv */
// self-checking bench for the gate sequencer
`timescale 1ns/10ps
`default_nettype none

module hbsg_sequencer_tb;
   localparam hbsg_pkg::hbsg_drv_type PAS = hbsg_pkg::DRV_PASSIVE;
   localparam hbsg_pkg::hbsg_drv_type CHG = hbsg_pkg::DRV_CHARGE;
   localparam hbsg_pkg::hbsg_drv_type SNK = hbsg_pkg::DRV_SINK;
   localparam hbsg_pkg::hbsg_drv_type HOF = hbsg_pkg::DRV_HARDOFF;
   localparam logic [5:0] ST = {4'h5, 2'h0}; // bridge 0 code 5
   localparam logic [5:0] H19 = hbsg_pkg::HOLD_STEP_LOW;
   localparam logic [5:0] H25 = hbsg_pkg::HOLD_STEP_HIGH;
   localparam logic [5:0] MX = hbsg_pkg::STEP_MAX;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic chipSelectPin = 1'b0;
   logic charge_pump_enable = 1'b0;
   logic hold_current_select = 1'b0;
   logic [1:0] bridge_drive_select [2] = '{2'h0, 2'h0};
   logic [1:0] bridge_pwm_select = 2'h0;
   logic [3:0] static_gate_current_code [2] = '{4'h5, 4'ha};
   hbsg_pkg::hbsg_timing_type timing [2] = '{2{48'h0003_0002_0001}}; // guard 3, blank 2, filter 1
   logic [1:0] pwmPin = 2'h0;
   hbsg_pkg::hbsg_bridge_out_type bridgeOut [2];
   logic [1:0] sequenceBusy;
   logic shoot;
   int fails = 0;
   int comparisons = 0;

   always #5 core_clk = ~core_clk;

   hbsg_sequencer dut (.core_clk, .rst_b, .clkEn(1'b1), .chipSelectPin, .charge_pump_enable,
      .hold_current_select, .bridge_drive_select, .bridge_pwm_select, .static_gate_current_code,
      .timing, .pwmPin, .bridgeOut, .sequenceBusy);
   hbsg_fet_model u_fet (.core_clk, .drive(bridgeOut[0]), .shootThrough(shoot));

   // ---------------------------------------------------------------
   // compare, drive and closing tasks
   // ---------------------------------------------------------------
   task automatic chkGate(string what, hbsg_pkg::hbsg_gate_type e, hbsg_pkg::hbsg_gate_type g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chkFlag(string what, logic e, logic g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask

   // checks bridge 0 for n cycles, one look per falling edge
   task automatic phase(hbsg_pkg::hbsg_drv_type ha, logic [5:0] hs, hbsg_pkg::hbsg_drv_type la, logic [5:0] ls, int n);
      repeat (n)
      begin
         chkGate("highSide", {ha, hs}, bridgeOut[0].highSide);
         chkGate("lowSide", {la, ls}, bridgeOut[0].lowSide);
         @(negedge core_clk);
      end
   endtask

   // chip-select rise commits the selection; bounded wait for busy
   task automatic cmd(logic [1:0] s);
      int t;
      @(negedge core_clk);
      bridge_drive_select = '{s, s};
      chipSelectPin = 1'b0;
      @(negedge core_clk);
      chipSelectPin = 1'b1;
      t = 0;
      while (sequenceBusy[0] !== 1'b1 && t < 300)
      begin
         @(negedge core_clk);
         t++;
      end
      chkFlag("busy", 1'b1, sequenceBusy[0]);
   endtask

   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic lowFromOff();
      cmd(hbsg_pkg::SEL_LOW_ON);
      phase(HOF, MX, CHG, ST, 5);
      chkFlag("busyDone", 1'b0, sequenceBusy[0]);
      phase(SNK, H19, CHG, H19, 2);
   endtask

   task automatic highGuard();
      cmd(hbsg_pkg::SEL_HIGH_ON);
      phase(SNK, ST, SNK, ST, 4);
      chkGate("bridge1High", {CHG, 6'h28}, bridgeOut[1].highSide);
      phase(CHG, ST, HOF, MX, 5);
      phase(CHG, H19, SNK, H19, 1);
      hold_current_select = 1'b1;
      @(negedge core_clk);
      phase(CHG, H25, SNK, H25, 2);
   endtask

   task automatic offThenHigh();
      cmd(hbsg_pkg::SEL_OFF_ACTIVE);
      phase(SNK, ST, SNK, ST, 4);
      phase(SNK, H25, SNK, H25, 2);
      cmd(hbsg_pkg::SEL_HIGH_ON);
      phase(CHG, ST, HOF, MX, 5);
      phase(CHG, H25, SNK, H25, 1);
      cmd(hbsg_pkg::SEL_OFF_PASSIVE);
      phase(SNK, ST, SNK, ST, 4);
      phase(PAS, 6'h00, PAS, 6'h00, 2);
   endtask

   // pump dropped in mid-sequence, then the bridge handed to its pwm pin
   task automatic pumpAndPwm();
      cmd(hbsg_pkg::SEL_LOW_ON);
      charge_pump_enable = 1'b0;
      @(negedge core_clk);
      phase(PAS, 6'h00, PAS, 6'h00, 3);
      charge_pump_enable = 1'b1;
      bridge_pwm_select = 2'h3;
      pwmPin = 2'h3;
      repeat (6) @(negedge core_clk);
      chkFlag("pwmMode", 1'b1, bridgeOut[0].pwmMode);
      chkFlag("pwmHigh", 1'b1, bridgeOut[0].lowSide.action === CHG);
      pwmPin = 2'h0;
      repeat (6) @(negedge core_clk);
      chkFlag("pwmLow", 1'b1, bridgeOut[0].lowSide.action === SNK);
   endtask

   initial
   begin
      #50us;
      fails++;
      conclude();
   end

   initial
   begin
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      charge_pump_enable = 1'b1;
      lowFromOff();
      highGuard();
      offThenHigh();
      pumpAndPwm();
      chkFlag("shootThrough", 1'b0, shoot);
      conclude();
   end
endmodule // hbsg_sequencer_tb
`default_nettype wire
